/* File: rtl/drs_params.svh */
// Purpose: Constants for the debug run status block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Offsets are word indexes on the plain register port.
`ifndef DRS_PARAMS_SVH
`define DRS_PARAMS_SVH

`define DRS_ADDR_W        3
`define DRS_OFF_CONTROL   3'h0
`define DRS_OFF_STATUS    3'h1
`define DRS_OFF_IRQ_STAT  3'h2
`define DRS_OFF_IRQ_MASK  3'h3
`define DRS_CTL_ENABLE    7
`define DRS_CTL_ARM       6
`define DRS_CTL_BEGIN     5
`define DRS_ST_CMPA       7
`define DRS_ST_CMPB       6
`define DRS_ST_ARMED      5
`define DRS_CNT_W         4
`define DRS_CNT_MAX       4'h8
`define DRS_CTL_RESET     3'h0
`define DRS_IRQ_W         3
`define DRS_EV_END        0
`define DRS_EV_CMPA       1
`define DRS_EV_CMPB       2

`endif

/* File: rtl/drs_pkg.sv */
// Purpose: Types for the debug run status block.
// Assumes: Constants come from drs_params.svh.
// Notes:   None.
package drs_pkg;
    typedef enum logic [1:0] {
        DRS_IDLE,
        DRS_WAIT_TRIG,
        DRS_CAPTURE
    } drs_state_t;

    typedef struct packed {
        logic cmpAHit;
        logic cmpBHit;
        logic trigger;
        logic fifoFull;
        logic fifoWrite;
        logic fifoRead;
    } drs_events_t;

    typedef struct packed {
        logic       enable;
        logic       arm;
        logic       beginTrace;
    } drs_ctl_t;
endpackage

/* File: rtl/drs_fill_counter.sv */
// Purpose: Counts valid FIFO words during a capture run.
// Assumes: Count saturates at eight words.
// Notes:   In end trace the FIFO wraps, so the count stays at eight once full.
`timescale 1ns/10ps
`include "drs_params.svh"
module drs_fill_counter (
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    input  wire logic                  clear,
    input  wire logic                  store,
    output logic [`DRS_CNT_W-1:0]      count
);
    always_ff @(posedge clock) begin
        if (!rst_b || clear) begin
            count <= '0;
        end else if (store && count != `DRS_CNT_MAX) begin
            count <= count + 4'h1;
        end
    end
endmodule

/* File: rtl/drs_debug_run_status.sv */
// Purpose: Debug run control and read-only run status with interrupt.
// Assumes: Register port reads return data one cycle after the read strobe.
// Notes:   Comparators, trigger modes and FIFO data live outside this block.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/10ps
`include "drs_params.svh"
module drs_debug_run_status (
    input  wire logic                    clock,
    input  wire logic                    rst_b,
    input  wire logic [`DRS_ADDR_W-1:0]  regAddr,
    input  wire logic [7:0]              regWdata,
    input  wire logic                    regWrite,
    input  wire logic                    regRead,
    output logic [7:0]                   regRdata,
    input  wire drs_pkg::drs_events_t    events,
    output logic                         fifoStore,
    output logic                         runActive,
    output logic                         irq
);
    drs_pkg::drs_state_t         state;
    drs_pkg::drs_ctl_t           ctl;
    logic                        cmpAFlag;
    logic                        cmpBFlag;
    logic [`DRS_CNT_W-1:0]       validCount;
    logic [`DRS_IRQ_W-1:0]       irqStat;
    logic [`DRS_IRQ_W-1:0]       irqMask;
    logic                        ctlWrite;
    logic                        armStart;
    logic                        manualEnd;
    logic                        autoEnd;
    logic                        runEnd;
    logic                        storing;
    logic [`DRS_IRQ_W-1:0]       evVec;
    logic [7:0]                  statusWord;

    function automatic logic hit(input logic [`DRS_ADDR_W-1:0] a, input logic [`DRS_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    assign ctlWrite  = regWrite && hit(regAddr, `DRS_OFF_CONTROL);
    assign armStart  = ctlWrite && regWdata[`DRS_CTL_ENABLE] && regWdata[`DRS_CTL_ARM]
                       && state == drs_pkg::DRS_IDLE;
    // Clearing arm or enable ends the run immediately.
    assign manualEnd = ctlWrite && (!regWdata[`DRS_CTL_ENABLE] || !regWdata[`DRS_CTL_ARM])
                       && state != drs_pkg::DRS_IDLE;
    // Begin trace ends on FIFO full, end trace ends on trigger.
    assign autoEnd   = (state == drs_pkg::DRS_CAPTURE && ctl.beginTrace && events.fifoFull)
                       || (state == drs_pkg::DRS_CAPTURE && !ctl.beginTrace && events.trigger);
    assign runEnd    = manualEnd || autoEnd;
    // Begin trace stores after trigger; end trace stores until trigger.
    assign storing   = state == drs_pkg::DRS_CAPTURE && events.fifoWrite && !runEnd;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state <= drs_pkg::DRS_IDLE;
        end else if (runEnd) begin
            state <= drs_pkg::DRS_IDLE;
        end else begin
            unique case (state)
                drs_pkg::DRS_IDLE: begin
                    if (armStart) begin
                        state <= regWdata[`DRS_CTL_BEGIN] ? drs_pkg::DRS_WAIT_TRIG : drs_pkg::DRS_CAPTURE;
                    end
                end
                drs_pkg::DRS_WAIT_TRIG: begin
                    if (events.trigger) begin
                        state <= drs_pkg::DRS_CAPTURE;
                    end
                end
                drs_pkg::DRS_CAPTURE: begin
                end
                default: begin
                    state <= drs_pkg::DRS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctl <= `DRS_CTL_RESET;
        end else if (ctlWrite) begin
            ctl.enable     <= regWdata[`DRS_CTL_ENABLE];
            // A run that ends in the same cycle still drops arm.
            ctl.arm        <= regWdata[`DRS_CTL_ARM] && regWdata[`DRS_CTL_ENABLE] && !autoEnd;
            ctl.beginTrace <= regWdata[`DRS_CTL_BEGIN];
        end else if (autoEnd) begin
            ctl.arm <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b || armStart) begin
            cmpAFlag <= 1'b0;
            cmpBFlag <= 1'b0;
        end else if (state != drs_pkg::DRS_IDLE) begin
            if (events.cmpAHit) begin
                cmpAFlag <= 1'b1;
            end
            if (events.cmpBHit) begin
                cmpBFlag <= 1'b1;
            end
        end
    end

    // Count clears at arming and only counts stores, never reads.
    drs_fill_counter i_drs_fill_counter (
        .clock (clock),
        .rst_b (rst_b),
        .clear (armStart),
        .store (storing),
        .count (validCount)
    );

    // Armed bit mirrors arm while enabled; status has no write path.
    assign statusWord = {cmpAFlag, cmpBFlag, ctl.arm && ctl.enable, 1'b0, validCount};

    assign evVec = {events.cmpBHit && state != drs_pkg::DRS_IDLE,
                    events.cmpAHit && state != drs_pkg::DRS_IDLE, runEnd};

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            irqStat <= '0;
        end else if (regRead && hit(regAddr, `DRS_OFF_IRQ_STAT)) begin
            irqStat <= evVec;
        end else begin
            irqStat <= irqStat | evVec;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            irqMask <= '0;
        end else if (regWrite && hit(regAddr, `DRS_OFF_IRQ_MASK)) begin
            irqMask <= regWdata[`DRS_IRQ_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStat & irqMask) || |(evVec & irqMask);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            unique case (regAddr)
                `DRS_OFF_CONTROL:  regRdata <= {ctl.enable, ctl.arm, ctl.beginTrace, 5'h00};
                `DRS_OFF_STATUS:   regRdata <= statusWord;
                `DRS_OFF_IRQ_STAT: regRdata <= {5'h00, irqStat};
                `DRS_OFF_IRQ_MASK: regRdata <= {5'h00, irqMask};
                default:           regRdata <= 8'h00;
            endcase
        end else begin
            regRdata <= 8'h00;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            fifoStore <= 1'b0;
            runActive <= 1'b0;
        end else begin
            fifoStore <= storing;
            runActive <= state != drs_pkg::DRS_IDLE && !runEnd;
        end
    end
endmodule

/* File: verif/drs_debug_run_status_properties.sv */
// Purpose: Port assertions for the debug run status block.
// Assumes: Read data stand one cycle after the read strobe.
// Notes:   Bound to the top module.
`timescale 1ns/10ps
`include "drs_params.svh"
module drs_status_properties (
    input wire logic                   clock,
    input wire logic                   rst_b,
    input wire logic [`DRS_ADDR_W-1:0] regAddr,
    input wire logic [7:0]             regWdata,
    input wire logic                   regWrite,
    input wire logic                   regRead,
    input wire logic [7:0]             regRdata,
    input wire drs_pkg::drs_events_t   events,
    input wire logic                   fifoStore,
    input wire logic                   runActive,
    input wire logic                   irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire stRd = regRead && regAddr == `DRS_OFF_STATUS;
    wire ctlWr = regWrite && regAddr == `DRS_OFF_CONTROL;
    wire armWr = ctlWr && regWdata[7] && regWdata[6];
    wire endC = events.trigger || events.fifoFull || ctlWr;
    property p_rd_idle; !regRead |=> regRdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("Read data outside slot.");
    property p_cnt_max; stRd |=> regRdata[3:0] <= `DRS_CNT_MAX; endproperty
    a_cnt_max: assert property (p_cnt_max) else $error("Count above eight.");
    property p_store_run; fifoStore |-> runActive; endproperty
    a_store_run: assert property (p_store_run) else $error("Store outside run.");
    property p_store_cause; fifoStore |-> $past(events.fifoWrite); endproperty
    a_store_cause: assert property (p_store_cause) else $error("Store without write.");
    property p_arm_cause; $rose(runActive) |-> $past(armWr) || $past(armWr, 2); endproperty
    a_arm_cause: assert property (p_arm_cause) else $error("Run without arm.");
    property p_manual_end; ctlWr && !(regWdata[7] && regWdata[6]) |-> ##[1:2] !runActive; endproperty
    a_manual_end: assert property (p_manual_end) else $error("Manual end missed.");
    property p_end_cause; $fell(runActive) |-> $past(endC) || $past(endC, 2); endproperty
    a_end_cause: assert property (p_end_cause) else $error("Run end without cause.");
    property p_armed_bit;
        stRd && !runActive && !$past(runActive) && !$past(armWr) |=> !regRdata[5];
    endproperty
    a_armed_bit: assert property (p_armed_bit) else $error("Armed flag while idle.");
    c_run: cover property ($fell(runActive));
    c_store: cover property (fifoStore ##1 fifoStore);
    c_irq: cover property ($rose(irq));
endmodule
bind drs_debug_run_status drs_status_properties i_drs_status_properties (
    .clock(clock), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .events(events), .fifoStore(fifoStore),
    .runActive(runActive), .irq(irq));

/* File: verif/drs_host_model.sv */
// Purpose: Debug host that reads captured words out of the trace store.
// Assumes: One read per cycle.
// Notes:   None.
`timescale 1ns/10ps
module drs_host_model (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       load,
    input  wire logic [3:0] count,
    output logic            fifoRead,
    output logic [3:0]      remaining
);
    // The host keeps its own tally of words left.
    always_ff @(posedge clock) begin
        if (!rst_b || load) begin
            remaining <= rst_b ? count : 4'h0;
        end else if (remaining != 4'h0) begin
            remaining <= remaining - 4'h1;
        end
    end
    assign fifoRead = remaining != 4'h0 && !load;
endmodule

/* File: verif/drs_debug_run_status_tb.sv */
// Purpose: Self-checking bench for the debug run status block.
// Assumes: Events are driven by the bench.
// Notes:   Rows hold {begin, A, B, writes, count}.
`timescale 1ns/10ps
`include "drs_params.svh"
module drs_debug_run_status_tb;
    logic                 clock = 0, rst_b = 0, regWrite = 0, regRead = 0, hostLoad = 0;
    logic [2:0]           regAddr = 3'h0;
    logic [7:0]           regWdata = 8'h00, regRdata, d;
    logic                 fifoStore, runActive, irq, hostRead;
    logic [3:0]           left;
    drs_pkg::drs_events_t ev = '0, evIn;
    int                   n_mismatch = 0, check_count = 0, cyc = 0;
    logic [11:0]          rows [4] = '{12'h000, 12'h455, 12'h298, 12'he88};
    always #2.5 clock = ~clock;
    always_comb begin
        evIn = ev;
        evIn.fifoRead = hostRead;
    end
    drs_debug_run_status i_drs_debug_run_status (.clock(clock), .rst_b(rst_b), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .events(evIn), .fifoStore(fifoStore), .runActive(runActive), .irq(irq));
    drs_host_model i_drs_host_model (.clock(clock), .rst_b(rst_b), .load(hostLoad), .count(d[3:0]),
        .fifoRead(hostRead), .remaining(left));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clock);
        regAddr <= a;
        regWdata <= v;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic pulse(input logic [5:0] v, input int k);
        repeat (k) begin
            @(posedge clock);
            ev <= v;
        end
        @(posedge clock);
        ev <= '0;
    endtask
    task automatic conclude();
        if (n_mismatch == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        wr(`DRS_OFF_IRQ_MASK, 8'h07);
        rd(`DRS_OFF_IRQ_MASK);
        chk("mask", d, 8'h07);
        for (int i = 0; i < 4; i++) begin
            wr(`DRS_OFF_CONTROL, {2'h3, rows[i][11], 5'h00});
            rd(`DRS_OFF_STATUS);
            chk("armed", d, 8'h20);
            if (rows[i][11]) pulse(6'h08, 1);
            pulse({rows[i][10:9], 4'h2}, rows[i][7:4]);
            pulse(rows[i][11] ? 6'h04 : 6'h08, 1);
            repeat (3) @(posedge clock);
            rd(`DRS_OFF_STATUS);
            chk("status", d, {rows[i][10:9], 2'h0, rows[i][3:0]});
            chk("irq", {7'h00, irq}, 8'h01);
            rd(`DRS_OFF_IRQ_STAT);
            chk("irqstat", d, {5'h00, rows[i][9], rows[i][10], 1'b1});
            @(posedge clock);
            #1 chk("irqclr", {7'h00, irq}, 8'h00);
        end
        wr(`DRS_OFF_IRQ_MASK, 8'h00);
        wr(`DRS_OFF_CONTROL, 8'hc0);
        pulse(6'h02, 3);
        #1 chk("store", {7'h00, fifoStore}, 8'h01);
        wr(`DRS_OFF_STATUS, 8'h00);
        rd(`DRS_OFF_STATUS);
        chk("runflags", d, 8'h23);
        chk("active", {7'h00, runActive}, 8'h01);
        wr(`DRS_OFF_CONTROL, 8'h80);
        repeat (2) @(posedge clock);
        #1 chk("manual", {7'h00, runActive}, 8'h00);
        rd(`DRS_OFF_STATUS);
        chk("endstat", d, 8'h03);
        @(posedge clock);
        hostLoad <= 1'b1;
        @(posedge clock);
        hostLoad <= 1'b0;
        repeat (5) @(posedge clock);
        rd(`DRS_OFF_STATUS);
        chk("readout", d, 8'h03);
        chk("left", {4'h0, left}, 8'h00);
        chk("masked", {7'h00, irq}, 8'h00);
        rd(`DRS_OFF_CONTROL);
        chk("control", d, 8'h80);
        rd(3'h5);
        chk("unmapped", d, 8'h00);
        wr(`DRS_OFF_CONTROL, 8'hc0);
        rst_b <= 1'b0;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        rd(`DRS_OFF_STATUS);
        chk("reset", {d[7:1], runActive}, 8'h00);
        conclude();
    end
endmodule
